// ### verilog/ssd_defines.svh
/*
 Offsets, field positions, reset values and timing counts of the
 full-duplex serial port. Assumes a 40 MHz core clock.
*/
`ifndef SSD_DEFINES_SVH
`define SSD_DEFINES_SVH

// register byte offsets on the bus
`define SSD_OFF_CTRL 8'h00
`define SSD_OFF_STAT 8'h04
`define SSD_OFF_DATA 8'h08
`define SSD_OFF_ISTAT 8'h0c
`define SSD_OFF_IMASK 8'h10

// control register fields
`define SSD_CTRL_MODE_LSB 0
`define SSD_CTRL_MODE_MSB 1
`define SSD_CTRL_START 2
`define SSD_CTRL_EXTCLK 3
`define SSD_MODE_OFF 2'b00
`define SSD_MODE_DUPLEX 2'b11
`define SSD_MODE_RST 2'b00

// status register fields
`define SSD_STAT_W 6
`define SSD_STAT_OPER 0
`define SSD_STAT_SEF 1
`define SSD_STAT_TX_BUFFER_FULL_FLAG 2
`define SSD_STAT_RECEIVE_COMPLETE_FLAG 3
`define SSD_STAT_OVERRUN_ERROR_FLAG 4
`define SSD_STAT_TX_UNDERRUN_FLAG 5

// interrupt status and mask field
`define SSD_IRQ_PORT 0

// pin levels
`define SSD_SO_IDLE 1'b1
`define SSD_SCLK_IDLE 1'b1

// byte framing
`define SSD_LAST_BIT 3'h7

// serial clock timing
`define SSD_CLK_NS 25
`define SSD_SCLK_HALF_NS 100
`define SSD_SCLK_HALF_CYC ((`SSD_SCLK_HALF_NS) / (`SSD_CLK_NS))

`endif

// ### verilog/ssd_pkg.sv
/*
 Types of the full-duplex serial port.
 Assumes nothing of its surroundings.
*/
package ssd_pkg;

   typedef enum logic [1:0] {
      SSD_ST_IDLE = 2'b00,
      SSD_ST_RUN = 2'b01,
      SSD_ST_WAIT = 2'b10
   } ssd_state_t;

endpackage

// ### verilog/ssd_sclk.sv
/*
 Serial clock unit: divides the core clock into the internal serial
 clock, or synchronises the peer's clock; gives one-cycle rise and
 fall pulses. Assumes the pin input comes from another clock domain.
*/
`timescale 1ns/1ps
`include "ssd_defines.svh"

module ssd_sclk
   import ssd_pkg::*;
#(
   parameter int HALF_CYC = `SSD_SCLK_HALF_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ext_sel,
   input wire logic run,
   input wire logic pin_in,
   output logic sclk_out,
   output logic rise,
   output logic fall
);

   logic [15:0] cnt_r;
   logic sync1_r;
   logic sync2_r;
   logic sync3_r;
   logic tick;

   assign tick = run && !ext_sel && (cnt_r == 16'(HALF_CYC - 1));

   // internal divider; idles high whenever the block is not shifting
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 16'h0000;
         sclk_out <= `SSD_SCLK_IDLE;
      end else if (!run || ext_sel) begin
         cnt_r <= 16'h0000;
         sclk_out <= `SSD_SCLK_IDLE;
      end else if (tick) begin
         cnt_r <= 16'h0000;
         sclk_out <= !sclk_out;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   // peer clock synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= `SSD_SCLK_IDLE;
         sync2_r <= `SSD_SCLK_IDLE;
         sync3_r <= `SSD_SCLK_IDLE;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rise <= 1'b0;
         fall <= 1'b0;
      end else if (ext_sel) begin
         rise <= sync2_r && !sync3_r;
         fall <= !sync2_r && sync3_r;
      end else begin
         rise <= tick && !sclk_out;
         fall <= tick && sclk_out;
      end
   end

endmodule

// ### verilog/ssd_top.sv
/*
 Full-duplex 8-bit clocked serial port with AHB-Lite register access:
 byte completion, continuation, pause and stop logic.
 Assumes a single-master AHB-Lite bus on CLOCK and a serial peer whose
 clock and data pins are asynchronous to CLOCK.
*/
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "ssd_defines.svh"

// Behaviour
// - byte done sets receive-complete, raises interrupt
// - internal clock, buffer full: reload, keep shifting
// - byte done while receive-complete set: overrun
// - internal clock, buffer empty: pause, pins idle
// - buffer write while paused resumes shifting
// - external clock: resend last byte, flag underrun
// - start cleared, nothing shifting: quiet immediate stop
// - start cleared while shifting: finish byte, interrupt
// - stopped: clear operating, shift-enable, buffer-full
// - normal stop: output high only for internal clock
// - mode off forces stop, clears start; status cleared only while operating
// - duplex mode 11; start sets operating, shift-enable
// - eighth received bit clears shift-enable on pause or stop
// - write while shifting sets buffer-full, else direct
module ssd_top
   import ssd_pkg::*;
#(
   parameter int HALF_CYC = `SSD_SCLK_HALF_CYC
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic SERIAL_CLOCK_IN,
   output logic SERIAL_CLOCK_OUT,
   output logic SERIAL_CLOCK_OE,
   input wire logic SERIAL_IN,
   output logic SERIAL_OUT,
   output logic INTERRUPT
);

   function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
      return (a[31:8] == 24'h000000) && (a[7:0] == off);
   endfunction

   logic rst_s1_r;
   logic rst_n_r;
   logic wr_pend_r;
   logic [31:0] addr_r;
   logic [1:0] mode_r;
   logic start_r;
   logic ext_r;
   ssd_state_t state_r;
   logic op_r;
   logic sef_r;
   logic tx_buffer_full_flag_r;
   logic receive_complete_flag_r;
   logic overrun_error_flag_r;
   logic tx_underrun_flag_r;
   logic resend_r;
   logic [7:0] sh_r;
   logic [2:0] bit_cnt_r;
   logic [7:0] tx_buf_r;
   logic [7:0] rx_buf_r;
   logic so_r;
   logic si1_r;
   logic si2_r;
   logic irq_stat_r;
   logic irq_mask_r;
   logic irq_r;
   logic sclk_oe_r;
   logic [`SSD_STAT_W-1:0] stat_v;
   logic sclk_rise;
   logic sclk_fall;

   // reset release through two flip-flops
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   wire logic ahb_go = HSEL && HREADY && HTRANS[1];
   wire logic rd_go = ahb_go && !HWRITE;
   wire logic rd_buf = rd_go && hit(HADDR, `SSD_OFF_DATA);
   wire logic rd_stat = rd_go && hit(HADDR, `SSD_OFF_STAT);
   wire logic wr_ctrl = wr_pend_r && hit(addr_r, `SSD_OFF_CTRL);
   wire logic wr_data = wr_pend_r && hit(addr_r, `SSD_OFF_DATA);
   wire logic wr_istat = wr_pend_r && hit(addr_r, `SSD_OFF_ISTAT);
   wire logic wr_imask = wr_pend_r && hit(addr_r, `SSD_OFF_IMASK);
   wire logic [1:0] mode_w = HWDATA[`SSD_CTRL_MODE_MSB:`SSD_CTRL_MODE_LSB];
   wire logic start_w = HWDATA[`SSD_CTRL_START];
   wire logic mode_off_wr = wr_ctrl && (mode_w == `SSD_MODE_OFF);
   wire logic force_stop = mode_off_wr && op_r;
   wire logic start_req = wr_ctrl && !op_r && start_w && (mode_w == `SSD_MODE_DUPLEX);
   wire logic stop_req = wr_ctrl && op_r && !mode_off_wr && !start_w;
   wire logic stop_now = stop_req && !sef_r;
   wire logic running = (state_r == SSD_ST_RUN);
   wire logic edge_rise = running && sclk_rise && !force_stop;
   wire logic edge_fall = running && sclk_fall && !force_stop;
   wire logic byte_done = edge_rise && (bit_cnt_r == `SSD_LAST_BIT);
   wire logic keep_on = byte_done && start_r && (tx_buffer_full_flag_r || ext_r || wr_data);
   wire logic pause = byte_done && start_r && !(tx_buffer_full_flag_r || ext_r || wr_data);
   wire logic resume = (state_r == SSD_ST_WAIT) && wr_data && start_r;
   wire logic underrun = keep_on && ext_r && !tx_buffer_full_flag_r && !wr_data;
   wire logic store_rx = byte_done && !(receive_complete_flag_r && !rd_buf);
   wire logic [7:0] load_byte = (tx_buffer_full_flag_r || !wr_data) ? tx_buf_r : HWDATA[7:0];
   wire logic [7:0] rx_byte = {sh_r[6:0], si2_r};

   // bus slave: zero wait states, always OKAY
   always_ff @(posedge CLOCK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wr_pend_r <= 1'b0;
         addr_r <= 32'h00000000;
         HREADYOUT <= 1'b0;
         HRESP <= 1'b0;
         HRDATA <= 32'h00000000;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         wr_pend_r <= ahb_go && HWRITE;
         if (ahb_go) begin
            addr_r <= HADDR;
         end
         if (rd_go) begin
            HRDATA <= 32'h00000000;
            if (hit(HADDR, `SSD_OFF_CTRL)) begin
               HRDATA[`SSD_CTRL_MODE_MSB:`SSD_CTRL_MODE_LSB] <= mode_r;
               HRDATA[`SSD_CTRL_START] <= start_r;
               HRDATA[`SSD_CTRL_EXTCLK] <= ext_r;
            end else if (rd_stat) begin
               HRDATA[`SSD_STAT_W-1:0] <= stat_v;
            end else if (rd_buf) begin
               HRDATA[7:0] <= rx_buf_r;
            end else if (hit(HADDR, `SSD_OFF_ISTAT)) begin
               HRDATA[`SSD_IRQ_PORT] <= irq_stat_r;
            end else if (hit(HADDR, `SSD_OFF_IMASK)) begin
               HRDATA[`SSD_IRQ_PORT] <= irq_mask_r;
            end
         end
      end
   end

   always_comb begin
      stat_v = '0;
      stat_v[`SSD_STAT_OPER] = op_r;
      stat_v[`SSD_STAT_SEF] = sef_r;
      stat_v[`SSD_STAT_TX_BUFFER_FULL_FLAG] = tx_buffer_full_flag_r;
      stat_v[`SSD_STAT_RECEIVE_COMPLETE_FLAG] = receive_complete_flag_r;
      stat_v[`SSD_STAT_OVERRUN_ERROR_FLAG] = overrun_error_flag_r;
      stat_v[`SSD_STAT_TX_UNDERRUN_FLAG] = tx_underrun_flag_r;
   end

   // control register; while operating only mode-off or start-clear take
   always_ff @(posedge CLOCK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mode_r <= `SSD_MODE_RST;
         start_r <= 1'b0;
         ext_r <= 1'b0;
      end else if (wr_ctrl) begin
         if (!op_r) begin
            mode_r <= mode_w;
            ext_r <= HWDATA[`SSD_CTRL_EXTCLK];
            start_r <= start_req;
         end else if (mode_off_wr) begin
            mode_r <= `SSD_MODE_OFF;
            start_r <= 1'b0;
         end else if (!start_w) begin
            start_r <= 1'b0;
         end
      end
   end

   // sequencing and the operating, shift-enable and buffer-full flags
   always_ff @(posedge CLOCK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= SSD_ST_IDLE;
         op_r <= 1'b0;
         sef_r <= 1'b0;
         tx_buffer_full_flag_r <= 1'b0;
      end else if (force_stop || stop_now || (byte_done && !start_r)) begin
         state_r <= SSD_ST_IDLE;
         op_r <= 1'b0;
         sef_r <= 1'b0;
         tx_buffer_full_flag_r <= 1'b0;
      end else if (start_req) begin
         state_r <= SSD_ST_RUN;
         op_r <= 1'b1;
         sef_r <= 1'b1;
         tx_buffer_full_flag_r <= 1'b0;
      end else if (keep_on) begin
         sef_r <= 1'b1;
         tx_buffer_full_flag_r <= tx_buffer_full_flag_r && wr_data;
      end else if (pause) begin
         state_r <= SSD_ST_WAIT;
         sef_r <= 1'b0;
      end else if (resume) begin
         state_r <= SSD_ST_RUN;
         sef_r <= 1'b1;
      end else if (running && wr_data) begin
         tx_buffer_full_flag_r <= 1'b1;
      end
   end

   // receive-complete and error flags; a set wins over a read clear
   always_ff @(posedge CLOCK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         receive_complete_flag_r <= 1'b0;
         overrun_error_flag_r <= 1'b0;
         tx_underrun_flag_r <= 1'b0;
      end else if (force_stop) begin
         receive_complete_flag_r <= 1'b0;
         overrun_error_flag_r <= 1'b0;
         tx_underrun_flag_r <= 1'b0;
      end else begin
         if (store_rx) begin
            receive_complete_flag_r <= 1'b1;
         end else if (rd_buf) begin
            receive_complete_flag_r <= 1'b0;
         end
         if (byte_done && !store_rx) begin
            overrun_error_flag_r <= 1'b1;
         end else if (rd_stat) begin
            overrun_error_flag_r <= 1'b0;
         end
         if (resend_r && edge_fall) begin
            tx_underrun_flag_r <= 1'b1;
         end else if (rd_stat) begin
            tx_underrun_flag_r <= 1'b0;
         end
      end
   end

   // a reloaded old byte is an underrun only once the peer clocks it out
   always_ff @(posedge CLOCK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         resend_r <= 1'b0;
      end else if (underrun) begin
         resend_r <= 1'b1;
      end else if (edge_fall || !running) begin
         resend_r <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         si1_r <= 1'b0;
         si2_r <= 1'b0;
      end else begin
         si1_r <= SERIAL_IN;
         si2_r <= si1_r;
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         tx_buf_r <= 8'h00;
         rx_buf_r <= 8'h00;
      end else begin
         if (wr_data) begin
            tx_buf_r <= HWDATA[7:0];
         end
         if (store_rx) begin
            rx_buf_r <= rx_byte;
         end
      end
   end

   // single shift register: msb leaves on falls, serial-in enters on rises
   always_ff @(posedge CLOCK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sh_r <= 8'h00;
         bit_cnt_r <= 3'h0;
      end else if (start_req) begin
         sh_r <= tx_buf_r;
         bit_cnt_r <= 3'h0;
      end else if (resume) begin
         sh_r <= HWDATA[7:0];
         bit_cnt_r <= 3'h0;
      end else if (keep_on) begin
         sh_r <= load_byte;
         bit_cnt_r <= 3'h0;
      end else if (edge_rise) begin
         sh_r <= rx_byte;
         bit_cnt_r <= bit_cnt_r + 3'h1;
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         so_r <= `SSD_SO_IDLE;
      end else if (mode_off_wr) begin
         so_r <= `SSD_SO_IDLE;
      end else if (start_req) begin
         so_r <= tx_buf_r[7];
      end else if (resume) begin
         so_r <= HWDATA[7];
      end else if (keep_on) begin
         so_r <= load_byte[7];
      end else if (pause || ((byte_done || stop_now) && !ext_r)) begin
         so_r <= `SSD_SO_IDLE;
      end else if (edge_fall && !byte_done) begin
         so_r <= sh_r[7];
      end
   end

   // interrupt: sticky, cleared by writing one, masked onto one level
   wire logic port_event = start_req || byte_done;

   always_ff @(posedge CLOCK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq_stat_r <= 1'b0;
         irq_mask_r <= 1'b0;
         irq_r <= 1'b0;
         sclk_oe_r <= 1'b0;
      end else begin
         if (port_event) begin
            irq_stat_r <= 1'b1;
         end else if (wr_istat && HWDATA[`SSD_IRQ_PORT]) begin
            irq_stat_r <= 1'b0;
         end
         if (wr_imask) begin
            irq_mask_r <= HWDATA[`SSD_IRQ_PORT];
         end
         irq_r <= irq_stat_r && irq_mask_r;
         sclk_oe_r <= !ext_r;
      end
   end

   assign SERIAL_OUT = so_r;
   assign SERIAL_CLOCK_OE = sclk_oe_r;
   assign INTERRUPT = irq_r;

   ssd_sclk #(
      .HALF_CYC(HALF_CYC)
   ) u_sclk (
      .clk(CLOCK),
      .rst_n(rst_n_r),
      .ext_sel(ext_r),
      .run(running && !ext_r),
      .pin_in(SERIAL_CLOCK_IN),
      .sclk_out(SERIAL_CLOCK_OUT),
      .rise(sclk_rise),
      .fall(sclk_fall)
   );

   default clocking @(posedge CLOCK); endclocking
   default disable iff (!rst_n_r);

   sequence s_int_done_stop;
      byte_done && !start_r && !ext_r;
   endsequence
   sequence s_high_idle;
      so_r && (state_r == SSD_ST_IDLE);
   endsequence

   chk_done_receive_complete_flag: assert property (
      store_rx |=> receive_complete_flag_r && irq_stat_r)
      else $error("byte done without receive-complete or interrupt");
   chk_reload_go: assert property (
      byte_done && start_r && tx_buffer_full_flag_r && !ext_r && !wr_data
      |=> !tx_buffer_full_flag_r && running && sh_r == $past(tx_buf_r))
      else $error("pending byte not reloaded");
   chk_overrun_set: assert property (
      byte_done && receive_complete_flag_r && !rd_buf |=> overrun_error_flag_r && rx_buf_r == $past(rx_buf_r))
      else $error("overrun not flagged");
   chk_pause_idle: assert property (
      pause |=> (state_r == SSD_ST_WAIT) && so_r && !sef_r ##1 SERIAL_CLOCK_OUT)
      else $error("pause left pins active");
   chk_resume_run: assert property (
      resume |=> running && sef_r && so_r == $past(HWDATA[7]))
      else $error("write did not resume");
   chk_ext_underrun: assert property (
      underrun |=> resend_r && running && sh_r == $past(tx_buf_r))
      else $error("old byte not reloaded for resend");
   chk_underrun_flag: assert property (
      resend_r && edge_fall |=> tx_underrun_flag_r)
      else $error("resend clocked out without underrun flag");
   chk_quiet_stop: assert property (
      stop_now && !irq_stat_r && !byte_done |=> !irq_stat_r && !op_r)
      else $error("immediate stop raised interrupt");
   chk_reserved_stop: assert property (
      byte_done && !start_r && !force_stop
      |=> irq_stat_r && !op_r && !sef_r && !tx_buffer_full_flag_r && state_r == SSD_ST_IDLE)
      else $error("reserved stop wrong");
   chk_stop_so_high: assert property (
      s_int_done_stop and !mode_off_wr |=> s_high_idle [*2])
      else $error("serial out not high after stop");
   chk_force_stop: assert property (
      force_stop |=> stat_v == '0 && !start_r && so_r ##1 SERIAL_CLOCK_OUT)
      else $error("forced stop incomplete");
   chk_start_flags: assert property (
      start_req |=> op_r && sef_r && so_r == $past(tx_buf_r[7]))
      else $error("start did not raise flags");
   chk_buffer_full: assert property (
      running && wr_data && !byte_done && !force_stop && !stop_now |=> tx_buffer_full_flag_r)
      else $error("write while shifting did not fill buffer");

endmodule

// ### verification/ssd_peer.sv
/*
 Serial peer: swaps one byte per frame with the port, MSB first.
 Assumes the bench resolves the shared clock pin from the port's clock enable.
*/
`timescale 1ns/1ps
module ssd_peer (
   input wire logic sclk_pin,
   input wire logic so,
   input wire logic [7:0] tx_base,
   input wire logic go,
   input wire logic [7:0] nbytes,
   output logic sclk_drv,
   output logic si,
   output logic [7:0] rx_last,
   output int rx_cnt
);
   logic [7:0] tx_sh = 8'h00;
   logic [7:0] rx_sh = 8'h00;
   logic gen = 1'b0;
   int nbit = 0;
   initial begin
      sclk_drv = 1'b1;
      si = 1'b0;
      rx_last = 8'h00;
      rx_cnt = 0;
   end
   // far clock runs only within frames, 200 ns period
   always @(posedge go) begin
      gen = 1'b1;
      #3;
      repeat (nbytes * 8) begin
         #100 sclk_drv = 1'b0;
         #100 sclk_drv = 1'b1;
      end
      gen = 1'b0;
   end
   // byte n of the run carries tx_base + n
   always @(negedge sclk_pin) begin
      if (nbit == 0) begin
         tx_sh = tx_base + rx_cnt[7:0];
      end
      si = tx_sh[7];
      tx_sh = {tx_sh[6:0], 1'b0};
   end
   always @(posedge sclk_pin) begin
      if ($time != 0) begin
         #(gen ? 60 : 20);
         rx_sh = {rx_sh[6:0], so};
         nbit++;
         if (nbit == 8) begin
            nbit = 0;
            rx_last = rx_sh;
            rx_cnt++;
            // data line left changing once the frame is over
            #40 si = ~si;
         end
      end
   end
endmodule

// ### verification/tb_ssd_top.sv
/*
 Self-checking bench of the full-duplex serial port.
 Assumes the design's assertions sit in its own files.
*/
`timescale 1ns/1ps
`include "ssd_defines.svh"
module tb_ssd_top;
   logic CLOCK = 1'b0;
   logic RST_N = 1'b0;
   logic [31:0] HADDR = 32'h0;
   logic [1:0] HTRANS = 2'h0;
   logic HWRITE = 1'b0;
   logic [31:0] HWDATA = 32'h0;
   logic [31:0] HRDATA, rd;
   logic HREADYOUT, HRESP, sclk_out, sclk_oe, sclk_drv, sclk_pin, so, si, irq;
   logic go = 1'b0;
   logic [7:0] nbytes = 8'h1;
   logic [7:0] pbase = 8'h0;
   logic [7:0] rx_last, a, b;
   logic [31:0] seed = 32'h77d8;
   int rx_cnt;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;

   ssd_top #(.HALF_CYC(4)) i_ssd_top (.CLOCK(CLOCK), .RST_N(RST_N), .HSEL(1'b1),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
      .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
      .SERIAL_CLOCK_IN(sclk_pin), .SERIAL_CLOCK_OUT(sclk_out), .SERIAL_CLOCK_OE(sclk_oe),
      .SERIAL_IN(si), .SERIAL_OUT(so), .INTERRUPT(irq));
   assign sclk_pin = (sclk_oe === 1'b1) ? sclk_out : sclk_drv;
   ssd_peer i_ssd_peer (.sclk_pin(sclk_pin), .so(so), .tx_base(pbase), .go(go),
      .nbytes(nbytes), .sclk_drv(sclk_drv), .si(si), .rx_last(rx_last), .rx_cnt(rx_cnt));

   always #12.5 CLOCK = ~CLOCK;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge CLOCK) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge CLOCK);
   endtask

   // one single-word transfer; read data lands in rd
   task automatic bus(input logic [7:0] ad, input logic wr, input logic [31:0] wd);
      @(posedge CLOCK);
      HTRANS <= 2'h2;
      HADDR <= {24'h0, ad};
      HWRITE <= wr;
      do begin
         @(posedge CLOCK);
      end while (HREADYOUT !== 1'b1);
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do begin
         @(posedge CLOCK);
      end while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask

   task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
      bus(ad, 1'b0, 32'h0);
      chk(rd, exp);
   endtask

   task automatic wait_rx(input int target);
      while (rx_cnt < target) begin
         @(posedge CLOCK);
      end
      wt(12);
   endtask

   task automatic pulse_go(input logic [7:0] cnt);
      nbytes <= cnt;
      go <= 1'b1;
      wt(2);
      go <= 1'b0;
   endtask

   initial begin
      seed = lfsr(seed);
      pbase <= seed[7:0];
      wt(6);
      RST_N <= 1'b1;
      wt(5);
      rdchk(`SSD_OFF_STAT, 32'h0);
      rdchk(8'h14, 32'h0);
      chk({27'h0, sclk_oe, so, sclk_out, irq, HRESP}, 32'h1c);
      seed = lfsr(seed);
      a = seed[7:0];
      b = 8'hff;
      // internal clock: back-to-back bytes, then pause with overrun
      bus(`SSD_OFF_DATA, 1'b1, {24'h0, a});
      bus(`SSD_OFF_CTRL, 1'b1, 32'h7);
      rdchk(`SSD_OFF_STAT, 32'h3);
      rdchk(`SSD_OFF_ISTAT, 32'h1);
      chk({31'h0, irq}, 32'h0);
      bus(`SSD_OFF_IMASK, 1'b1, 32'h1);
      wt(2);
      chk({31'h0, irq}, 32'h1);
      bus(`SSD_OFF_ISTAT, 1'b1, 32'h1);
      wt(2);
      chk({31'h0, irq}, 32'h0);
      bus(`SSD_OFF_DATA, 1'b1, {24'h0, b});
      rdchk(`SSD_OFF_STAT, 32'h7);
      wait_rx(1);
      chk({24'h0, rx_last}, {24'h0, a});
      chk({31'h0, irq}, 32'h1);
      rdchk(`SSD_OFF_STAT, 32'hb);
      wait_rx(2);
      chk({24'h0, rx_last}, {24'h0, b});
      rdchk(`SSD_OFF_STAT, 32'h19);
      wt(20);
      chk({30'h0, so, sclk_out}, 32'h3);
      rdchk(`SSD_OFF_DATA, {24'h0, pbase});
      rdchk(`SSD_OFF_STAT, 32'h1);
      bus(`SSD_OFF_ISTAT, 1'b1, 32'h1);
      bus(`SSD_OFF_CTRL, 1'b1, 32'h3);
      rdchk(`SSD_OFF_STAT, 32'h0);
      rdchk(`SSD_OFF_ISTAT, 32'h0);
      // restart, pause, resume by write, then reserved stop
      seed = lfsr(seed);
      a = seed[7:0];
      seed = lfsr(seed);
      b = seed[7:0];
      bus(`SSD_OFF_DATA, 1'b1, {24'h0, a});
      bus(`SSD_OFF_CTRL, 1'b1, 32'h7);
      wait_rx(3);
      rdchk(`SSD_OFF_STAT, 32'h9);
      chk({31'h0, so}, 32'h1);
      rdchk(`SSD_OFF_DATA, {24'h0, pbase + 8'h2});
      bus(`SSD_OFF_DATA, 1'b1, {24'h0, b});
      rdchk(`SSD_OFF_STAT, 32'h3);
      bus(`SSD_OFF_ISTAT, 1'b1, 32'h1);
      bus(`SSD_OFF_CTRL, 1'b1, 32'h3);
      wait_rx(4);
      chk({24'h0, rx_last}, {24'h0, b});
      rdchk(`SSD_OFF_STAT, 32'h8);
      rdchk(`SSD_OFF_ISTAT, 32'h1);
      chk({31'h0, so}, 32'h1);
      rdchk(`SSD_OFF_DATA, {24'h0, pbase + 8'h3});
      // external clock: resend with underrun, reserved stop, mode off
      seed = lfsr(seed);
      a = seed[7:0];
      bus(`SSD_OFF_DATA, 1'b1, {24'h0, a});
      bus(`SSD_OFF_CTRL, 1'b1, 32'hf);
      pulse_go(8'h2);
      wait_rx(6);
      rdchk(`SSD_OFF_STAT, 32'h3b);
      chk({31'h0, sclk_oe}, 32'h0);
      chk({24'h0, rx_last}, {24'h0, a});
      rdchk(`SSD_OFF_DATA, {24'h0, pbase + 8'h4});
      bus(`SSD_OFF_CTRL, 1'b1, 32'hb);
      pulse_go(8'h1);
      wait_rx(7);
      chk({24'h0, rx_last}, {24'h0, a});
      rdchk(`SSD_OFF_STAT, 32'h28);
      wt(20);
      chk({31'h0, so}, {31'h0, a[0]});
      bus(`SSD_OFF_CTRL, 1'b1, 32'h0);
      wt(3);
      chk({31'h0, so}, 32'h1);
      rdchk(`SSD_OFF_STAT, 32'h8);
      // forced stop in mid-byte with the internal clock
      seed = lfsr(seed);
      bus(`SSD_OFF_DATA, 1'b1, {24'h0, seed[7:0]});
      bus(`SSD_OFF_CTRL, 1'b1, 32'h7);
      wt(20);
      bus(`SSD_OFF_CTRL, 1'b1, 32'h0);
      wt(3);
      rdchk(`SSD_OFF_STAT, 32'h0);
      rdchk(`SSD_OFF_CTRL, 32'h0);
      chk({30'h0, so, sclk_out}, 32'h3);
      wrap_up();
   end
endmodule
